// file: imc_pkg.sv
// Package of the interrupt mode control slice: register map, field layout,
// reset values and the carrier types shared by the design files.
// Assumes a 32-bit classic Wishbone register bus and a single system clock.
package imc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [31:0] IMC_CTRL_ADDR   = 32'hffff_e030;
	localparam logic [31:0] IMC_STATUS_ADDR = 32'hffff_e040;
	localparam logic [31:0] IMC_MASK_ADDR   = 32'hffff_e044;

	// ----------------------------------------------------------------
	// Field layout inside one source byte of the control register
	// ----------------------------------------------------------------
	localparam int IMC_NUM_SRC     = 3;
	localparam int IMC_SRC_STRIDE  = 8;
	localparam int IMC_MODE_LSB    = 5;
	localparam int IMC_ROUTE_BIT   = 4;
	localparam int IMC_LVL_LSB     = 0;
	localparam int IMC_NUM_DMA_CH  = 8;

	// ----------------------------------------------------------------
	// Detection mode codes
	// ----------------------------------------------------------------
	localparam logic [1:0] IMC_MODE_HIGH_LEVEL = 2'h1;
	localparam logic [1:0] IMC_MODE_RISE_EDGE  = 2'h3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]  IMC_MODE_RST   = 2'h0;
	localparam logic        IMC_ROUTE_RST  = 1'b0;
	localparam logic [2:0]  IMC_LVL_RST    = 3'h0;
	localparam logic [2:0]  IMC_STATUS_RST = 3'h0;
	localparam logic [2:0]  IMC_MASK_RST   = 3'h0;
	localparam logic [2:0]  IMC_LVL_OFF    = 3'h0;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] mode;
		logic       dma_route;
		logic [2:0] level_or_chan;
	} imc_src_cfg_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [31:0] adr;
		logic [31:0] dat;
	} imc_wb_req_t;

	typedef struct packed {
		logic prev;
		logic hit;
	} imc_det_st_t;

endpackage

// file: imc_detect.sv
// One request detector: high level or rising edge, chosen by a mode code.
// Assumes the request input is synchronous to clk_i.
module imc_detect (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Request and mode
	input  wire logic       req_i,
	input  wire logic [1:0] mode_i,
	// Detected request, one flop late
	output logic            hit_o
);

	imc_pkg::imc_det_st_t st_q;
	imc_pkg::imc_det_st_t st_d;

	always_comb begin
		st_d      = st_q;
		st_d.prev = req_i;
		// Codes other than level or edge detect nothing
		if (mode_i == imc_pkg::IMC_MODE_HIGH_LEVEL) begin
			st_d.hit = req_i;
		end else if (mode_i == imc_pkg::IMC_MODE_RISE_EDGE) begin
			st_d.hit = req_i & ~st_q.prev;
		end else begin
			st_d.hit = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign hit_o = st_q.hit;

endmodule

// file: imc_slice.sv
// Interrupt mode control slice for sources 48, 49 and 50: control register,
// request detection, CPU or DMA routing, sticky event status with mask.
// Assumes a classic Wishbone master and requests synchronous to clk_i.
//
// Overview of operation
// - Source 48 level-high detection on mode 01
// - Source 49 rising-edge detection per mode field
// - Route flag 1 makes source a DMA trigger
// - Route 0: field is CPU level, 000 off
// - Route 1: field selects DMA channel 0-7
// - Source 50 route flag selects DMA trigger
//
// Implementation choice: the Wishbone slave port.
module imc_slice #(
	parameter int NUM_DMA_CH = imc_pkg::IMC_NUM_DMA_CH
) (
	// Clock and reset
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// Wishbone slave
	input  wire logic                         cyc_i,
	input  wire logic                         stb_i,
	input  wire logic                         we_i,
	input  wire logic [3:0]                   sel_i,
	input  wire logic [31:0]                  adr_i,
	input  wire logic [31:0]                  dat_i,
	output logic      [31:0]                  dat_o,
	output logic                              ack_o,
	// Interrupt source requests, bit 0 is source 48
	input  wire logic [2:0]                   src_req_i,
	// Towards the CPU core
	output logic      [2:0]                   cpu_req_o,
	output imc_pkg::imc_src_cfg_t [2:0]       src_cfg_o,
	// Towards the DMA controller
	output logic      [NUM_DMA_CH-1:0]        dma_trig_o,
	// Event interrupt
	output logic                              irq_o
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// A 3-bit channel code reaches exactly eight channels
	if (NUM_DMA_CH != imc_pkg::IMC_NUM_DMA_CH) begin : g_bad_ch
		$error("NUM_DMA_CH must be 8");
	end

	// Every source field must fit inside its own byte lane
	if (imc_pkg::IMC_MODE_LSB + 2 > imc_pkg::IMC_SRC_STRIDE) begin : g_bad_layout
		$error("Source field wider than its byte lane");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		imc_pkg::imc_src_cfg_t [2:0] cfg;
		logic [2:0]                  status;
		logic [2:0]                  mask;
		logic                        ack;
		logic [31:0]                 rdat;
		logic [2:0]                  cpu_req;
		logic [NUM_DMA_CH-1:0]       dma_trig;
	} imc_state_t;

	imc_state_t          st_q;
	imc_state_t          st_d;
	imc_pkg::imc_wb_req_t wb;
	logic [2:0]          hit;

	assign wb.cyc = cyc_i;
	assign wb.stb = stb_i;
	assign wb.we  = we_i;
	assign wb.sel = sel_i;
	assign wb.adr = adr_i;
	assign wb.dat = dat_i;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Exact compare: every other address in the page answers zero
	logic adr_ctrl;
	logic adr_status;
	logic adr_mask;

	assign adr_ctrl   = (wb.adr == imc_pkg::IMC_CTRL_ADDR);
	assign adr_status = (wb.adr == imc_pkg::IMC_STATUS_ADDR);
	assign adr_mask   = (wb.adr == imc_pkg::IMC_MASK_ADDR);

	// ----------------------------------------------------------------
	// Request detectors
	// ----------------------------------------------------------------
	for (genvar i = 0; i < imc_pkg::IMC_NUM_SRC; i++) begin : g_det
		imc_detect u_det (
			.clk_i  (clk_i),
			.rst_i  (rst_i),
			.req_i  (src_req_i[i]),
			.mode_i (st_q.cfg[i].mode),
			.hit_o  (hit[i])
		);
	end

	// ----------------------------------------------------------------
	// Read-back image of the control register
	// ----------------------------------------------------------------
	function automatic logic [31:0] ctrl_image(input imc_pkg::imc_src_cfg_t [2:0] cfg);
		logic [31:0] w;
		w = '0;
		// Bits 7, 3 of each byte and all of bits 31:24 stay zero
		for (int k = 0; k < imc_pkg::IMC_NUM_SRC; k++) begin
			w[k*imc_pkg::IMC_SRC_STRIDE + imc_pkg::IMC_MODE_LSB +: 2] = cfg[k].mode;
			w[k*imc_pkg::IMC_SRC_STRIDE + imc_pkg::IMC_ROUTE_BIT]    = cfg[k].dma_route;
			w[k*imc_pkg::IMC_SRC_STRIDE + imc_pkg::IMC_LVL_LSB +: 3] = cfg[k].level_or_chan;
		end
		return w;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic req_now;
		logic wr_now;
		logic [2:0] w1c;
		req_now = 1'b0;
		wr_now  = 1'b0;
		w1c     = '0;
		st_d    = st_q;

		// Bus: ack one cycle after the request, dropped the cycle after
		req_now = wb.cyc & wb.stb & ~st_q.ack;
		wr_now  = wb.cyc & wb.stb & wb.we & st_q.ack;
		st_d.ack = req_now;
		if (req_now) begin
			// Unmapped addresses still answer, with zero
			if (adr_ctrl) begin
				st_d.rdat = ctrl_image(st_q.cfg);
			end else if (adr_status) begin
				st_d.rdat = {29'h0000_0000, st_q.status};
			end else if (adr_mask) begin
				st_d.rdat = {29'h0000_0000, st_q.mask};
			end else begin
				st_d.rdat = 32'h0000_0000;
			end
		end

		// Writes take effect at the edge where ack is seen
		if (wr_now) begin
			// Each byte lane carries one source; lane 3 is reserved
			if (adr_ctrl) begin
				for (int k = 0; k < imc_pkg::IMC_NUM_SRC; k++) begin
					if (wb.sel[k]) begin
						st_d.cfg[k].mode          = wb.dat[k*imc_pkg::IMC_SRC_STRIDE + imc_pkg::IMC_MODE_LSB +: 2];
						st_d.cfg[k].dma_route     = wb.dat[k*imc_pkg::IMC_SRC_STRIDE + imc_pkg::IMC_ROUTE_BIT];
						st_d.cfg[k].level_or_chan = wb.dat[k*imc_pkg::IMC_SRC_STRIDE + imc_pkg::IMC_LVL_LSB +: 3];
					end
				end
			end else if (adr_status) begin
				if (wb.sel[0]) begin
					w1c = wb.dat[2:0];
				end
			end else if (adr_mask) begin
				if (wb.sel[0]) begin
					st_d.mask = wb.dat[2:0];
				end
			end
		end

		// A detection in the clearing cycle is kept
		st_d.status = (st_q.status & ~w1c) | hit;

		// Routing of each detected request
		st_d.cpu_req  = '0;
		st_d.dma_trig = '0;
		for (int k = 0; k < imc_pkg::IMC_NUM_SRC; k++) begin
			if (hit[k]) begin
				if (st_q.cfg[k].dma_route) begin
					st_d.dma_trig[st_q.cfg[k].level_or_chan] = 1'b1;
				end else if (st_q.cfg[k].level_or_chan != imc_pkg::IMC_LVL_OFF) begin
					st_d.cpu_req[k] = 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int k = 0; k < imc_pkg::IMC_NUM_SRC; k++) begin
				st_q.cfg[k].mode          <= imc_pkg::IMC_MODE_RST;
				st_q.cfg[k].dma_route     <= imc_pkg::IMC_ROUTE_RST;
				st_q.cfg[k].level_or_chan <= imc_pkg::IMC_LVL_RST;
			end
			st_q.status   <= imc_pkg::IMC_STATUS_RST;
			st_q.mask     <= imc_pkg::IMC_MASK_RST;
			st_q.ack      <= 1'b0;
			st_q.rdat     <= 32'h0000_0000;
			st_q.cpu_req  <= '0;
			st_q.dma_trig <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign ack_o      = st_q.ack;
	assign dat_o      = st_q.rdat;
	assign cpu_req_o  = st_q.cpu_req;
	assign src_cfg_o  = st_q.cfg;
	assign dma_trig_o = st_q.dma_trig;

	// ----------------------------------------------------------------
	// Event interrupt
	// ----------------------------------------------------------------
	// Level output, so a masked-in bit holds it until cleared
	// Clearing the mask hides a pending event without losing it
	assign irq_o      = |(st_q.status & st_q.mask);

endmodule

// file: imc_slice_monitor.sv
// Checker for the interrupt mode control slice, watching its ports only.
// Assumes the bench holds a source's config steady around its requests.
module imc_slice_monitor (
	input wire logic                         clk_i,
	input wire logic                         rst_i,
	input wire logic                         we_i,
	input wire logic [31:0]                  adr_i,
	input wire logic [31:0]                  dat_o,
	input wire logic                         ack_o,
	input wire logic [2:0]                   src_req_i,
	input wire logic [2:0]                   cpu_req_o,
	input wire imc_pkg::imc_src_cfg_t [2:0]  src_cfg_o,
	input wire logic [7:0]                   dma_trig_o,
	input wire logic                         irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_level_high_det: assert property ((src_req_i[0] && src_cfg_o[0].mode == 2'h1 && !src_cfg_o[0].dma_route
		&& src_cfg_o[0].level_or_chan != 3'h0) |-> ##2 cpu_req_o[0]) else $error("level request lost");
	a_rise_edge_pulse: assert property (($rose(src_req_i[1]) && src_cfg_o[1].mode == 2'h3 && !src_cfg_o[1].dma_route
		&& src_cfg_o[1].level_or_chan != 3'h0) |-> ##2 cpu_req_o[1] ##1 !cpu_req_o[1]) else $error("edge pulse wrong");
	a_cpu_needs_level: assert property (cpu_req_o[0] |-> !src_cfg_o[0].dma_route
		&& src_cfg_o[0].level_or_chan != 3'h0) else $error("cpu request while off or routed");
	a_dma_chan_sel: assert property ((src_req_i[0] && src_cfg_o[0].mode == 2'h1 && src_cfg_o[0].dma_route)
		|-> ##2 dma_trig_o[src_cfg_o[0].level_or_chan]) else $error("dma channel not hit");
	a_src50_dma: assert property ((src_req_i[2] && src_cfg_o[2].mode == 2'h1 && src_cfg_o[2].dma_route)
		|-> ##2 (dma_trig_o[src_cfg_o[2].level_or_chan] && !cpu_req_o[2])) else $error("source 50 routing wrong");
	a_reserved_zero: assert property ((ack_o && !we_i && adr_i == imc_pkg::IMC_CTRL_ADDR)
		|-> (dat_o & 32'hff88_8888) == 32'h0000_0000) else $error("reserved bits not zero");
	a_reset_clears: assert property (disable iff (1'b0) rst_i |=> (src_cfg_o == 18'h0_0000
		&& cpu_req_o == 3'h0 && dma_trig_o == 8'h00 && !irq_o)) else $error("reset left state");
	c_edge: cover property (cpu_req_o[1]);
	c_dma: cover property (dma_trig_o[7]);
	c_irq: cover property (irq_o);
endmodule

bind imc_slice imc_slice_monitor u_mon (.clk_i, .rst_i, .we_i, .adr_i, .dat_o, .ack_o, .src_req_i,
	.cpu_req_o, .src_cfg_o, .dma_trig_o, .irq_o);

// file: imc_src_model.sv
// Model of the on-chip interrupt sources that feed the slice.
// Assumes one request at a time, driven off the slice's clock.
module imc_src_model (
	input  wire logic       clk_i,
	output logic      [2:0] req_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req_o = 3'h0;
	task automatic raise(input int k, input int n);
		@(posedge clk_i) req_o[k] <= 1'b1;
		repeat (n) @(posedge clk_i);
		req_o[k] <= 1'b0;
		// Low gap keeps consecutive edges apart
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// file: interrupt_mode_control_slice_bench.sv
// Self-checking bench for the slice: Wishbone tasks and source scenarios.
// Assumes the source model and the bound checker are compiled with it.
module interrupt_mode_control_slice_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] CA = imc_pkg::IMC_CTRL_ADDR;
	localparam logic [31:0] SA = imc_pkg::IMC_STATUS_ADDR;
	localparam logic [31:0] MA = imc_pkg::IMC_MASK_ADDR;
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
	logic [3:0] sel_i;
	logic [31:0] adr_i, dat_i, dat_o, q;
	logic [2:0] src_req_i, cpu_req_o;
	logic [7:0] dma_trig_o;
	imc_pkg::imc_src_cfg_t [2:0] src_cfg_o;
	int fails = 0, checked = 0, c, d;
	imc_slice u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i, .dat_o, .ack_o,
		.src_req_i, .cpu_req_o, .src_cfg_o, .dma_trig_o, .irq_o);
	imc_src_model u_src (.clk_i, .req_o(src_req_i));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic wb(input logic w, input logic [31:0] a, dw, input logic [3:0] s, output logic [31:0] r);
		int t;
		t = 0;
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, dw, s};
		@(posedge clk_i);
		while (ack_o !== 1'b1 && t < 50) begin
			@(posedge clk_i);
			t++;
		end
		if (t == 50) fails++;
		r = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask
	task automatic chk(input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Requests source k for n cycles and counts cycles of its cpu line and of one dma channel
	task automatic cnt(input int k, n, ch, output int cc, dc);
		cc = 0;
		dc = 0;
		fork
			u_src.raise(k, n);
		join_none
		repeat (14) begin
			@(posedge clk_i);
			#1;
			if ($isunknown({cpu_req_o[k], dma_trig_o[ch]})) chk({cpu_req_o[k], dma_trig_o[ch]}, 32'h0000_0000);
			if (cpu_req_o[k] === 1'b1) cc++;
			if (dma_trig_o[ch] === 1'b1) dc++;
		end
		@(posedge clk_i);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		wb(0, CA, 32'h0000_0000, 4'hf, q); chk(q, 32'h0000_0000);
		wb(0, MA, 32'h0000_0000, 4'h1, q); chk(q, 32'h0000_0000);
	endtask
	task automatic t_reserved;
		wb(1, CA, 32'hffff_ffff, 4'hf, q);
		wb(0, CA, 32'h0000_0000, 4'hf, q); chk(q, 32'h0077_7777);
		wb(1, 32'hffff_e0fc, 32'hffff_ffff, 4'hf, q);
		wb(0, 32'hffff_e0fc, 32'h0000_0000, 4'hf, q); chk(q, 32'h0000_0000);
	endtask
	task automatic t_level;
		wb(1, MA, 32'h0000_0001, 4'h1, q);
		wb(1, CA, 32'h0000_0025, 4'hf, q);
		cnt(0, 5, 0, c, d); chk(c, 5);
		chk(irq_o, 1);
		wb(1, SA, 32'h0000_0001, 4'h1, q); chk(irq_o, 0);
		wb(1, MA, 32'h0000_0000, 4'h1, q);
		wb(1, CA, 32'h0000_0020, 4'h1, q);
		cnt(0, 5, 0, c, d); chk(c, 0);
		chk(irq_o, 0);
		wb(0, SA, 32'h0000_0000, 4'h1, q); chk(q, 32'h0000_0001);
		wb(1, SA, 32'h0000_0001, 4'h1, q);
	endtask
	task automatic t_edge;
		wb(1, CA, 32'h0000_6300, 4'h2, q);
		cnt(1, 5, 0, c, d); chk(c, 1);
	endtask
	task automatic t_dma;
		for (int ch = 0; ch < 8; ch++) begin
			wb(1, CA, 32'h0000_0030 | 32'(ch), 4'h1, q);
			cnt(0, 4, ch, c, d); chk(d, 4);
			chk(c, 0);
		end
	endtask
	task automatic t_src50;
		wb(1, CA, 32'h0031_0000, 4'h4, q);
		cnt(2, 4, 1, c, d); chk(d, 4);
		chk(c, 0);
		wb(1, CA, 32'h0021_0000, 4'h4, q);
		cnt(2, 4, 1, c, d); chk(c, 4);
		chk(32'(src_cfg_o[2]), 32'h0000_0011);
		wb(1, CA, 32'h0041_0000, 4'h4, q);
		cnt(2, 4, 1, c, d); chk(c, 0);
	endtask
	initial begin
		{rst_i, cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} = {1'b1, 71'h0};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_reserved;
		t_level;
		t_edge;
		t_dma;
		t_src50;
		wrap_up;
	end
	initial begin
		#100000;
		fails++;
		wrap_up;
	end
endmodule
